// ==== logic/lbst_pkg.sv ====
// Purpose: Shared constants for the local-bus slave image translator.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Control words of both images share one field layout.
package lbst_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int          APB_ADDR_W     = 12;
    localparam logic [11:0] OFF_IMG0_CTL   = 12'hF00;
    localparam logic [11:0] OFF_IMG0_AT    = 12'hF04;
    localparam logic [11:0] OFF_IMG1_CTL   = 12'hF10;
    localparam logic [11:0] OFF_IMG1_AT    = 12'hF14;
    localparam logic [11:0] OFF_STATUS     = 12'hF18;
    localparam logic [11:0] OFF_LAST_ADDR  = 12'hF1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_POST_BIT  = 31;
    localparam int CTL_SPACE_BIT = 24;
    localparam int CTL_PFTCH_BIT = 23;
    localparam int AT_XADDR_LSB  = 16;
    localparam int AT_XADDR_W    = 16;
    localparam int AT_SIZE_LSB   = 4;
    localparam int AT_SIZE_W     = 4;
    localparam int AT_EN_BIT     = 0;
    localparam int ST_IMAGE_BIT  = 0;
    localparam int ST_RESP_LSB   = 1;
    localparam int ST_CS_BIT     = 4;
    localparam int ST_PCIRST_BIT = 8;

    // Writable bits; all others read as zero
    localparam logic [31:0] CTL_MASK       = 32'h8180_0000;
    localparam logic [31:0] CTL_EEPROM_MSK = 32'h8100_0000;
    localparam logic [31:0] AT_MASK        = 32'hFFFF_00F1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
    localparam logic [31:0] AT_RESET       = 32'h0000_0000;

    // Lowest translated line for block size code 0 (64 Kbyte window)
    localparam logic [4:0]  WINDOW_LOW_LINE = 5'h10;

    // ----------------------------------------------------------------
    // Access handling codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RESP_DELAYED_READ  = 3'b000,
        RESP_PREFETCH_READ = 3'b001,
        RESP_DELAYED_WRITE = 3'b010,
        RESP_POSTED_WRITE  = 3'b011,
        RESP_BUS_ERROR     = 3'b100
    } lbst_resp_t;

endpackage : lbst_pkg

// ==== logic/lbst_translator.sv ====
// Purpose: Two local-bus slave images: select, translate, classify.
// Assumes: Local address, direction and burst pins are stable while the
//          chip select is held; only select and PCI reset pins pass the synchroniser.
// Notes:   Image 0 settings follow the PCI reset pin and EEPROM load;
//          image 1 settings follow presetn only.
//
// What this block does
// [RL1] With chip select asserted and image select high, image 1 settings govern the access.
// [RL2] With chip select asserted and image select low, image 0 settings govern the access.
// [RL3] Translated upper address lines are replaced by the image's 16-bit translation address.
// [RL4] Substitution happens only while the image's translation enable bit is 1.
// [RL5] The 4-bit block size code sets a window of 64 Kbyte times two to the code.
// [RL6] Translated lines run from A31 down to line 16 plus the block size code.
// [RL7] A single read is a delayed prefetched read for prefetch on and memory space, else delayed.
// [RL8] A burst read is a delayed read in memory space and a bus error in I/O space.
// [RL9] A single write is posted only for posting on and memory space, else delayed.
// [RL10] A burst write is always posted in memory space and a bus error in I/O space.
// [RL11] The space select bit sends the access to memory space at 0 and I/O space at 1.
// [RL12] Image 1 settings are never loaded from EEPROM and general reset clears them.
// [RL13] PCI reset clears image 0 translation settings, which an EEPROM load may then set.
// [RL14] Lines below the translated range, and all lines with translation off, pass unchanged.
`timescale 1ns/100ps

module lbst_translator
    import lbst_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  pci_reset_n,
    input  wire logic                  eeprom_load,
    input  wire logic [31:0]           eeprom_img0_ctl,
    input  wire logic [31:0]           eeprom_img0_at,
    input  wire logic                  pci_chip_select_n,
    input  wire logic                  image_select_input,
    input  wire logic [31:0]           local_addr,
    input  wire logic                  local_write,
    input  wire logic                  local_burst,
    output logic                       access_valid,
    output lbst_resp_t                 access_resp,
    output logic                       local_bus_error,
    output logic                       image_used,
    output logic                       pci_space_select,
    output logic      [31:0]           pci_addr
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge_strb

    function automatic logic [31:0] translate(
        input logic [31:0] addr,
        input logic [31:0] at
    );
        logic [4:0]  low_line;
        logic [31:0] upper;
        low_line = WINDOW_LOW_LINE + at[AT_SIZE_LSB +: AT_SIZE_W]; // [RL5] [RL6]
        upper    = 32'hFFFF_FFFF << low_line;                    // [RL6]
        if (at[AT_EN_BIT])                                       // [RL4]
        begin
            return (addr & ~upper)                               // [RL14]
                 | ({at[AT_XADDR_LSB +: AT_XADDR_W], 16'h0000} & upper); // [RL3]
        end
        return addr;                                             // [RL14]
    endfunction : translate

    function automatic lbst_resp_t classify(
        input logic [31:0] ctl,
        input logic        wr,
        input logic        burst
    );
        logic io_space;
        io_space = ctl[CTL_SPACE_BIT];                           // [RL11]
        if (!wr && !burst)
        begin
            return (ctl[CTL_PFTCH_BIT] && !io_space) ?           // [RL7]
                   RESP_PREFETCH_READ : RESP_DELAYED_READ;
        end
        if (!wr)
        begin
            return io_space ? RESP_BUS_ERROR : RESP_DELAYED_READ; // [RL8]
        end
        if (!burst)
        begin
            return (ctl[CTL_POST_BIT] && !io_space) ?            // [RL9]
                   RESP_POSTED_WRITE : RESP_DELAYED_WRITE;
        end
        return io_space ? RESP_BUS_ERROR : RESP_POSTED_WRITE;    // [RL10]
    endfunction : classify

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Third stage lets a change count only once two samples agree.
    logic [2:0] cs_sync;
    logic [2:0] sel_sync;
    logic [2:0] prst_sync;
    logic       cs_active;
    logic       sel_level;
    logic       pci_rst_active;
    logic       cs_start;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_sync   <= 3'h7;
            sel_sync  <= 3'h0;
            prst_sync <= 3'h0;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], pci_chip_select_n};
            sel_sync  <= {sel_sync[1:0], image_select_input};
            prst_sync <= {prst_sync[1:0], pci_reset_n};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_active      <= 1'b0;
            sel_level      <= 1'b0;
            pci_rst_active <= 1'b1;
        end
        else
        begin
            if (cs_sync[1] == cs_sync[2])
            begin
                cs_active <= ~cs_sync[2];
            end
            if (sel_sync[1] == sel_sync[2])
            begin
                sel_level <= sel_sync[2];
            end
            if (prst_sync[1] == prst_sync[2])
            begin
                pci_rst_active <= ~prst_sync[2];
            end
        end
    end

    assign cs_start = !cs_sync[1] && !cs_sync[2] && !cs_active;

    // ----------------------------------------------------------------
    // Image registers
    // ----------------------------------------------------------------
    logic [31:0] img0_ctl;
    logic [31:0] img0_at;
    logic [31:0] img1_ctl;
    logic [31:0] img1_at;
    logic        apb_write;
    logic        apb_setup;

    assign apb_write = psel && penable && pwrite;
    assign apb_setup = psel && !penable;

    // An EEPROM load outranks a register write in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            img0_ctl <= CTL_RESET;
            img0_at  <= AT_RESET;
        end
        else if (pci_rst_active)
        begin
            img0_ctl <= CTL_RESET;                               // [RL13]
            img0_at  <= AT_RESET;                                // [RL13]
        end
        else if (eeprom_load)
        begin
            // Prefetch enable has no EEPROM bit and keeps its value
            img0_ctl <= (img0_ctl & ~CTL_EEPROM_MSK)
                      | (eeprom_img0_ctl & CTL_EEPROM_MSK);
            img0_at  <= eeprom_img0_at & AT_MASK;                // [RL13]
        end
        else if (apb_write && paddr == OFF_IMG0_CTL)
        begin
            img0_ctl <= merge_strb(img0_ctl, pwdata, pstrb, CTL_MASK);
        end
        else if (apb_write && paddr == OFF_IMG0_AT)
        begin
            img0_at <= merge_strb(img0_at, pwdata, pstrb, AT_MASK);
        end
    end

    // No EEPROM path reaches image 1.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            img1_ctl <= CTL_RESET;                               // [RL12]
            img1_at  <= AT_RESET;                                // [RL12]
        end
        else if (apb_write && paddr == OFF_IMG1_CTL)
        begin
            img1_ctl <= merge_strb(img1_ctl, pwdata, pstrb, CTL_MASK);
        end
        else if (apb_write && paddr == OFF_IMG1_AT)
        begin
            img1_at <= merge_strb(img1_at, pwdata, pstrb, AT_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    logic [31:0] sel_ctl;
    logic [31:0] sel_at;

    always_comb
    begin
        sel_ctl = img0_ctl;                                      // [RL2]
        sel_at  = img0_at;                                       // [RL2]
        if (sel_level)
        begin
            sel_ctl = img1_ctl;                                  // [RL1]
            sel_at  = img1_at;                                   // [RL1]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            access_valid <= 1'b0;
        end
        else
        begin
            access_valid <= cs_start;
        end
    end

    // Results hold until the next chip select assertion.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            access_resp      <= RESP_DELAYED_READ;
            local_bus_error  <= 1'b0;
            image_used       <= 1'b0;
            pci_space_select <= 1'b0;
            pci_addr         <= 32'h0000_0000;
        end
        else if (cs_start)
        begin
            access_resp      <= classify(sel_ctl, local_write, local_burst);
            local_bus_error  <= (classify(sel_ctl, local_write, local_burst)
                                 == RESP_BUS_ERROR);             // [RL8] [RL10]
            image_used       <= sel_level;                       // [RL1] [RL2]
            pci_space_select <= sel_ctl[CTL_SPACE_BIT];          // [RL11]
            pci_addr         <= translate(local_addr, sel_at);   // [RL3] [RL14]
        end
    end

    // ----------------------------------------------------------------
    // APB read side
    // ----------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb
    begin
        status_word                              = 32'h0000_0000;
        status_word[ST_IMAGE_BIT]                = image_used;
        status_word[ST_RESP_LSB +: 3]            = access_resp;
        status_word[ST_CS_BIT]                   = cs_active;
        status_word[ST_PCIRST_BIT]               = pci_rst_active;
    end

    always_comb
    begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            OFF_IMG0_CTL:  next_prdata = img0_ctl;
            OFF_IMG0_AT:   next_prdata = img0_at;
            OFF_IMG1_CTL:  next_prdata = img1_ctl;
            OFF_IMG1_AT:   next_prdata = img1_at;
            OFF_STATUS:    next_prdata = status_word;
            OFF_LAST_ADDR: next_prdata = pci_addr;
            default:       next_pslverr = 1'b1;
        endcase
    end

    // Captured in the setup cycle so that read data comes from a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;

endmodule : lbst_translator

// ==== verification/lbst_checker.sv ====
// Purpose: Port assertions for the slave image translator.
// Assumes: Local pins hold from chip select fall until access_valid.
// Notes:   Bound into every translator instance.
`timescale 1ns/100ps
module lbst_checker
    import lbst_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pci_chip_select_n,
    input wire logic [31:0] local_addr,
    input wire logic        local_write,
    input wire logic        local_burst,
    input wire logic        access_valid,
    input wire lbst_resp_t  access_resp,
    input wire logic        local_bus_error,
    input wire logic        pci_space_select,
    input wire logic [31:0] pci_addr
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Decode
    // ----
    property p_err; access_valid |-> local_bus_error == (access_resp == RESP_BUS_ERROR);
    endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
    property p_bwr; access_valid && local_write && local_burst |-> access_resp ==
        (pci_space_select ? RESP_BUS_ERROR : RESP_POSTED_WRITE); endproperty
    a_bwr: assert property (p_bwr) else $error("burst write wrong");
    property p_brd; access_valid && !local_write && local_burst |-> access_resp ==
        (pci_space_select ? RESP_BUS_ERROR : RESP_DELAYED_READ); endproperty
    a_brd: assert property (p_brd) else $error("burst read wrong");
    property p_srd; access_valid && !local_write && !local_burst
        |-> access_resp inside {RESP_DELAYED_READ, RESP_PREFETCH_READ}; endproperty
    a_srd: assert property (p_srd) else $error("single read wrong");
    property p_swr; access_valid && local_write && !local_burst
        |-> access_resp inside {RESP_DELAYED_WRITE, RESP_POSTED_WRITE}; endproperty
    a_swr: assert property (p_swr) else $error("single write wrong");
    property p_mem; access_valid && !local_burst && access_resp inside
        {RESP_PREFETCH_READ, RESP_POSTED_WRITE} |-> !pci_space_select; endproperty
    a_mem: assert property (p_mem) else $error("io space sped up");
    // ----
    // Address and select
    // ----
    property p_low; access_valid |-> pci_addr[15:0] == local_addr[15:0]; endproperty
    a_low: assert property (p_low) else $error("low lines changed");
    property p_cs; access_valid |-> !pci_chip_select_n && !$past(pci_chip_select_n, 3);
    endproperty
    a_cs: assert property (p_cs) else $error("result without select");
endmodule : lbst_checker

bind lbst_translator lbst_checker u_chk (.pclk, .presetn, .pci_chip_select_n, .local_addr,
    .local_write, .local_burst, .access_valid, .access_resp, .local_bus_error,
    .pci_space_select, .pci_addr);

// ==== verification/lbst_local_master.sv ====
// Purpose: Local processor bus master for the slave image pins.
// Assumes: One access at a time; select released between accesses.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/100ps
module lbst_local_master
(
    input  wire logic        pclk,
    input  wire logic        access_valid,
    output logic             pci_chip_select_n,
    output logic             image_select_input,
    output logic      [31:0] local_addr,
    output logic             local_write,
    output logic             local_burst
);
    initial
    begin
        {pci_chip_select_n, image_select_input, local_addr, local_write, local_burst} = 36'h8_0000_0000;
    end
    task automatic run(input logic img, input logic [31:0] a, input logic wr,
                       input logic bu, output logic ok);
        int n;
        @(posedge pclk);
        image_select_input <= img;
        local_addr         <= a;
        local_write        <= wr;
        local_burst        <= bu;
        // Image select must pass the synchroniser before the select does
        repeat (3) @(posedge pclk);
        pci_chip_select_n  <= 1'b0;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (access_valid !== 1'b1 && n < 20);
        ok = (access_valid === 1'b1);
        pci_chip_select_n  <= 1'b1;
        local_addr         <= ~a;
        local_write        <= ~wr;
        local_burst        <= ~bu;
        repeat (3) @(posedge pclk);
    endtask : run
endmodule : lbst_local_master

// ==== verification/lbst_translator_tb.sv ====
// Purpose: Self-checking bench for the slave image translator.
// Assumes: Zero-wait APB slave; local select pins pass a 3-edge synchroniser.
// Notes:   Image 1 carries the decode sweep, image 0 the EEPROM path.
`timescale 1ns/100ps
module lbst_translator_tb
    import lbst_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pci_reset_n, eeprom_load, err, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, eeprom_img0_ctl, eeprom_img0_at, local_addr, pci_addr, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, pci_chip_select_n, image_select_input, local_write;
    logic        local_burst, access_valid, local_bus_error, image_used, pci_space_select;
    lbst_resp_t  access_resp;
    int          mismatches, n_checks;

    lbst_translator u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pci_reset_n, .eeprom_load, .eeprom_img0_ctl,
        .eeprom_img0_at, .pci_chip_select_n, .image_select_input, .local_addr, .local_write,
        .local_burst, .access_valid, .access_resp, .local_bus_error, .image_used,
        .pci_space_select, .pci_addr);
    lbst_local_master u_master (.pclk, .access_valid, .pci_chip_select_n, .image_select_input,
        .local_addr, .local_write, .local_burst);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ----
    // Tasks
    // ----
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic acc(input logic img, input logic [31:0] a, input logic wr, input logic bu);
        u_master.run(img, a, wr, bu, ok);
        if (ok !== 1'b1)
        begin
            mismatches++;
            stop_test();
        end
    endtask : acc
    function automatic logic [2:0] exp_resp(input logic en, input logic io,
                                            input logic wr, input logic bu);
        if (bu)
            return io ? 3'h4 : (wr ? 3'h3 : 3'h0);
        return {1'b0, wr, en && !io};
    endfunction : exp_resp
    function automatic logic [31:0] xl(input logic [31:0] at, input logic [31:0] a);
        logic [31:0] m;
        m = 32'hFFFF_FFFF << (16 + at[7:4]);
        return at[0] ? ((at & m) | (a & ~m)) : a;
    endfunction : xl
    // ----
    // Sequence
    // ----
    initial
    begin
        {presetn, psel, penable, pwrite, eeprom_load, paddr} = 17'h0;
        {pwdata, eeprom_img0_ctl, eeprom_img0_at} = 96'h0;
        pci_reset_n = 1'b1;
        pstrb = 4'hF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'hF00 + 12'(i[1] * 16 + i[0] * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        $display("reset values done");
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, OFF_IMG1_CTL, {k[3], 6'h0, k[2], k[3], 23'h0});
            acc(1'b1, 32'h1357_9BDF, k[1], k[0]);
            chk("result", 32'({1'b1, k[2], exp_resp(k[3], k[2], k[1], k[0])}),
                32'({image_used, pci_space_select, access_resp}));
            chk("pass address", 32'h1357_9BDF, pci_addr);
        end
        $display("decode sweep done");
        for (int b = 0; b < 16; b++)
        begin
            apb(1'b1, OFF_IMG1_AT, {16'hA5C3, 8'h0, 4'(b), 4'h1});
            acc(1'b1, 32'h5A3C_1234, 1'b0, 1'b0);
            chk("translated", xl({16'hA5C3, 8'h0, 4'(b), 4'h1}, 32'h5A3C_1234), pci_addr);
        end
        pstrb <= 4'hC;
        apb(1'b1, OFF_IMG1_AT, 32'h0);
        pstrb <= 4'hF;
        $display("translation sweep done");
        eeprom_img0_ctl <= 32'h0100_0000;
        eeprom_img0_at  <= 32'h1234_0031;
        eeprom_load     <= 1'b1;
        @(posedge pclk);
        eeprom_load     <= 1'b0;
        acc(1'b0, 32'hCAFE_5678, 1'b1, 1'b1);
        chk("image 0 result", 32'h1C, 32'({image_used, pci_space_select, local_bus_error,
            access_resp}));
        chk("image 0 address", xl(32'h1234_0031, 32'hCAFE_5678), pci_addr);
        apb(1'b0, OFF_IMG0_CTL, 32'h0);
        chk("image 0 control", 32'h0100_0000, rd);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h0000_0008, rd);
        apb(1'b0, OFF_LAST_ADDR, 32'h0);
        chk("last address", xl(32'h1234_0031, 32'hCAFE_5678), rd);
        apb(1'b1, OFF_IMG0_CTL, 32'hFFFF_FFFF);
        apb(1'b0, OFF_IMG0_CTL, 32'h0);
        chk("image 0 control write", 32'h8180_0000, rd);
        pci_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        pci_reset_n <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, OFF_IMG0_AT, 32'h0);
        chk("image 0 after pci reset", 32'h0, rd);
        apb(1'b0, OFF_IMG0_CTL, 32'h0);
        chk("image 0 control after pci reset", 32'h0, rd);
        apb(1'b0, OFF_IMG1_AT, 32'h0);
        chk("image 1 kept", 32'h0000_00F1, rd);
        $display("image 0 path done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_IMG1_AT, 32'h0);
        chk("image 1 after reset", 32'h0, rd);
        $display("general reset done");
        stop_test();
    end
endmodule : lbst_translator_tb
